/* File: hw/plcs_regs.sv */
// Purpose: link config/status bank with AHB-Lite slave and wait timers
// Assumes: status inputs synchronous to ref_clk_in
// Notes:   one-cycle zero-wait slave, OKAY always
`timescale 1ns/1ns
`include "plcs_defines.svh"

module plcs_regs
    import plcs_pkg::*;
#(
    parameter int  REV_WIDTH = 4,
    parameter logic [3:0] REV_VALUE = 4'h5 // arbitrary value
) (
    input  wire logic        ref_clk_in,                 // 20 MHz clock
    input  wire logic        nrst_in,                    // async reset, low
    input  wire logic        hsel_in,                    // slave select
    input  wire logic [31:0] haddr_in,                   // byte address
    input  wire logic [1:0]  htrans_in,                  // transfer type
    input  wire logic        hwrite_in,                  // write
    input  wire logic [2:0]  hsize_in,                   // size
    input  wire logic [31:0] hwdata_in,                  // write data
    input  wire logic        hready_in,                  // bus ready
    output logic      [31:0] hrdata_out,                 // read data
    output logic             hreadyout_out,              // slave ready
    output logic             hresp_out,                  // response
    input  wire logic [7:0]  echo_first_height_in,       // peak 1
    input  wire logic [7:0]  echo_second_height_in,      // peak 2
    input  wire logic [7:0]  echo_third_height_in,       // peak 3
    input  wire logic [7:0]  echo_fourth_height_in,      // peak 4
    input  wire logic [4:0]  echo_polarity_in,           // peaks 4..0 sign
    input  wire logic [15:0] reflect_summary_in,         // fault/state/act
    input  wire logic [15:0] strap_low_in,               // sampled straps
    input  wire logic [15:0] strap_high_in,              // sampled straps
    input  wire logic [2:0]  rx_symbol_in,               // received code
    input  wire logic        rx_symbol_valid_in,         // code strobe
    input  wire logic        real_link_status_in,        // true link
    input  wire logic        link_control_in,            // internal link ctl
    input  wire logic        autoneg_en_in,              // autoneg on
    input  wire logic        maxwait_start_in,           // start max timer
    input  wire logic        minwait_start_in,           // start min timer
    output logic      [2:0]  sent_wake_symbol_out,       // tx wake code
    output logic      [2:0]  sent_sleep_symbol_out,      // tx sleep code
    output logic             wake_received_out,          // wake command seen
    output logic             sleep_received_out,         // sleep command seen
    output logic             maxwait_done_out,           // max timer expired
    output logic             minwait_done_out,           // min timer expired
    output logic             fallback_lock_en_out,       // fallback energy/lock
    output logic             fallback_energy_en_out,     // fallback energy
    output logic             bypass_dsp_reset_out,       // no dsp reset
    output logic             link_status_out,            // reported status
    output logic             link_control_out            // effective ctl
);

    // elaboration check: the revision field is four bits wide
    if (REV_WIDTH != 4) begin : g_rev_check
        $error("plcs_regs: REV_WIDTH must be 4");
    end

    localparam logic [7:0] US_CYC = 8'(`PLCS_US_CYCLES);

    typedef struct packed {
        plcs_phase_e phase;
        logic [11:0] idx;
        logic [15:0] codes;
        logic [15:0] thresh;
        logic [15:0] maxwait;
        logic [15:0] phyctrl;
        logic [31:0] rdata;
        logic [6:0]  wake_cnt;
        logic [6:0]  sleep_cnt;
        logic        wake_rx;
        logic        sleep_rx;
        logic [7:0]  us_div;
        logic        max_run;
        logic [19:0] max_cnt;
        logic        max_done;
        logic        min_run;
        logic [11:0] min_cnt;
        logic        min_done;
        logic        link_stat;
        logic        link_ctl;
    } plcs_state_s;

    plcs_state_s st_ff;
    plcs_state_s nxt_st;

    // ==========================================================
    // read mux
    function automatic plcs_word_t rd_word(input logic [11:0] idx,
                                           input plcs_state_s s);
        plcs_word_t w;
        w = 16'h0000;
        unique case (idx)
            `PLCS_IDX_PEAK_A:   w = {echo_second_height_in, echo_first_height_in};
            `PLCS_IDX_PEAK_B:   w = {echo_fourth_height_in, echo_third_height_in};
            `PLCS_IDX_SIGNS:    w = {11'h000, echo_polarity_in} & `PLCS_MASK_SIGNS;
            `PLCS_IDX_SUMMARY:  w = reflect_summary_in & `PLCS_MASK_SUMMARY;
            `PLCS_IDX_STRAP_LO: w = strap_low_in;
            `PLCS_IDX_STRAP_HI: w = strap_high_in;
            `PLCS_IDX_REVISION: w = {12'h000, REV_VALUE};
            `PLCS_IDX_CODES:    w = s.codes;
            `PLCS_IDX_THRESH:   w = s.thresh;
            `PLCS_IDX_MAXWAIT:  w = s.maxwait;
            `PLCS_IDX_PHYCTRL:  w = s.phyctrl;
            default:            w = 16'h0000;
        endcase
        return w;
    endfunction : rd_word

    // ==========================================================
    // next state
    always_comb begin
        logic [15:0] wd;
        logic        take;
        logic [2:0]  rxw;
        logic [2:0]  rxs;
        logic [6:0]  wlim;
        logic [6:0]  slim;
        wd     = hwdata_in[15:0];
        take   = hsel_in && hready_in && htrans_in[1];
        rxw    = st_ff.codes[`PLCS_RXW_LSB +: 3];
        rxs    = st_ff.codes[`PLCS_RXS_LSB +: 3];
        wlim   = st_ff.thresh[`PLCS_WLIM_LSB +: 7];
        slim   = st_ff.thresh[`PLCS_SLIM_LSB +: 7];
        nxt_st = st_ff;
        // write data phase
        if (st_ff.phase == PLCS_AP_WR) begin
            unique case (st_ff.idx)
                `PLCS_IDX_CODES:   nxt_st.codes   = wd & `PLCS_MASK_CODES;
                `PLCS_IDX_THRESH:  nxt_st.thresh  = wd & `PLCS_MASK_THRESH;
                `PLCS_IDX_MAXWAIT: nxt_st.maxwait = wd;
                `PLCS_IDX_PHYCTRL: nxt_st.phyctrl = wd & `PLCS_MASK_PHYCTRL;
                default: ;
            endcase
        end
        nxt_st.phase = PLCS_AP_IDLE;
        if (take) begin
            nxt_st.idx   = haddr_in[13:2];
            nxt_st.phase = hwrite_in ? PLCS_AP_WR : PLCS_AP_RD;
            if (!hwrite_in)
                nxt_st.rdata = {16'h0000, rd_word(haddr_in[13:2], st_ff)};
        end
        if (|haddr_in[31:14] && take) begin
            nxt_st.idx = 12'hFFF;
            // a write out of range leaves the last read data standing
            if (!hwrite_in)
                nxt_st.rdata = 32'h0000_0000;
        end
        // consecutive symbol counting
        nxt_st.wake_rx  = 1'b0;
        nxt_st.sleep_rx = 1'b0;
        if (rx_symbol_valid_in) begin
            if (rx_symbol_in == rxw) begin
                nxt_st.wake_cnt = (st_ff.wake_cnt == 7'h7F) ? st_ff.wake_cnt
                                                          : st_ff.wake_cnt + 7'd1;
                // saturated count keeps the flag up on long runs
                nxt_st.wake_rx  = (nxt_st.wake_cnt >= wlim);
            end else begin
                nxt_st.wake_cnt = 7'd0;
            end
            if (rx_symbol_in == rxs) begin
                nxt_st.sleep_cnt = (st_ff.sleep_cnt == 7'h7F) ? st_ff.sleep_cnt
                                                            : st_ff.sleep_cnt + 7'd1;
                nxt_st.sleep_rx  = (nxt_st.sleep_cnt >= slim);
            end else begin
                nxt_st.sleep_cnt = 7'd0;
            end
        end else begin
            nxt_st.wake_rx  = st_ff.wake_rx;
            nxt_st.sleep_rx = st_ff.sleep_rx;
        end
        // microsecond tick
        nxt_st.us_div = (st_ff.us_div == US_CYC - 8'd1) ? 8'd0 : st_ff.us_div + 8'd1;
        // wait timers, value times sixteen microseconds
        if (maxwait_start_in) begin
            nxt_st.max_run  = 1'b1;
            nxt_st.max_done = 1'b0;
            nxt_st.max_cnt  = {st_ff.maxwait, 4'h0};
        end else if (st_ff.max_run && st_ff.us_div == 8'd0) begin
            if (st_ff.max_cnt <= 20'd1) begin
                nxt_st.max_run  = 1'b0;
                nxt_st.max_done = 1'b1;
            end else begin
                nxt_st.max_cnt = st_ff.max_cnt - 20'd1;
            end
        end
        if (minwait_start_in) begin
            nxt_st.min_run  = 1'b1;
            nxt_st.min_done = 1'b0;
            nxt_st.min_cnt  = {st_ff.phyctrl[7:0], 4'h0};
        end else if (st_ff.min_run && st_ff.us_div == 8'd0) begin
            if (st_ff.min_cnt <= 12'd1) begin
                nxt_st.min_run  = 1'b0;
                nxt_st.min_done = 1'b1;
            end else begin
                nxt_st.min_cnt = st_ff.min_cnt - 12'd1;
            end
        end
        // link status and control overrides
        nxt_st.link_stat = st_ff.phyctrl[`PLCS_FLS_EN_BIT] ?
                           st_ff.phyctrl[`PLCS_FLS_VAL_BIT] : real_link_status_in;
        nxt_st.link_ctl  = (st_ff.phyctrl[`PLCS_LCO_EN_BIT] && autoneg_en_in) ?
                           st_ff.phyctrl[`PLCS_LCO_VAL_BIT] : link_control_in;
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff         <= '0;
            st_ff.phase   <= PLCS_AP_IDLE;
            st_ff.codes   <= `PLCS_RST_CODES;
            st_ff.thresh  <= `PLCS_RST_THRESH;
            st_ff.maxwait <= `PLCS_RST_MAXWAIT;
            st_ff.phyctrl <= `PLCS_RST_PHYCTRL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // outputs
    assign hrdata_out             = st_ff.rdata;
    assign hreadyout_out          = 1'b1;
    assign hresp_out              = 1'b0;
    assign sent_wake_symbol_out   = st_ff.codes[`PLCS_TXW_LSB +: 3];
    assign sent_sleep_symbol_out  = st_ff.codes[`PLCS_TXS_LSB +: 3];
    assign wake_received_out      = st_ff.wake_rx;
    assign sleep_received_out     = st_ff.sleep_rx;
    assign maxwait_done_out       = st_ff.max_done;
    assign minwait_done_out       = st_ff.min_done;
    assign fallback_lock_en_out   = st_ff.phyctrl[`PLCS_FB_LOCK_BIT];
    assign fallback_energy_en_out = st_ff.phyctrl[`PLCS_FB_ENERGY_BIT];
    assign bypass_dsp_reset_out   = st_ff.phyctrl[`PLCS_BYP_DSP_BIT];
    assign link_status_out        = st_ff.link_stat;
    assign link_control_out       = st_ff.link_ctl;

endmodule : plcs_regs

/* File: hw/plcs_defines.svh */
// What this block does
// - echo peak heights, two per word, read-only
// - strap readback bits at fixed positions
// - wake code to send, bits 11-9
// - sleep code to send, bits 8-6
// - expected wake code, bits 5-3
// - expected sleep code, bits 2-0
// - wake received after enough consecutive wake symbols
// - sleep received after enough consecutive sleep symbols
// - max wait timer, microseconds times sixteen
// - min wait timer, microseconds times sixteen
// - fallback on energy loss or lock
// - fallback on energy loss alone
// - bypass datapath reset from coding sublayer
// - forced link status replaces real status
// - link control override when autoneg enabled
//
// Purpose: offsets, fields, resets and timing counts of the link config bank
// Assumes: printed offsets are register indices; byte address is four times index
// Notes:   definitions only
`ifndef PLCS_DEFINES_SVH
`define PLCS_DEFINES_SVH

// ==========================================================
// register indices
`define PLCS_IDX_PEAK_A      12'h030C
`define PLCS_IDX_PEAK_B      12'h030D
`define PLCS_IDX_SIGNS       12'h030E
`define PLCS_IDX_SUMMARY     12'h030F
`define PLCS_IDX_STRAP_LO    12'h045D
`define PLCS_IDX_STRAP_HI    12'h045E
`define PLCS_IDX_REVISION    12'h0466
`define PLCS_IDX_CODES       12'h0514
`define PLCS_IDX_THRESH      12'h0515
`define PLCS_IDX_MAXWAIT     12'h0518
`define PLCS_IDX_PHYCTRL     12'h0519

// ==========================================================
// reset values
`define PLCS_RST_CODES       16'h08E3
`define PLCS_RST_THRESH      16'h0808
`define PLCS_RST_MAXWAIT     16'h17CE
`define PLCS_RST_PHYCTRL     16'h003D

// ==========================================================
// writable and readback masks
`define PLCS_MASK_CODES      16'h0FFF
`define PLCS_MASK_THRESH     16'h7F7F
`define PLCS_MASK_SIGNS      16'h001F
`define PLCS_MASK_SUMMARY    16'h3FF3
`define PLCS_MASK_PHYCTRL    16'h7FFF

// ==========================================================
// field positions
`define PLCS_TXW_LSB         9
`define PLCS_TXS_LSB         6
`define PLCS_RXW_LSB         3
`define PLCS_RXS_LSB         0
`define PLCS_WLIM_LSB        8
`define PLCS_SLIM_LSB        0
`define PLCS_FB_LOCK_BIT     14
`define PLCS_FB_ENERGY_BIT   13
`define PLCS_BYP_DSP_BIT     12
`define PLCS_FLS_VAL_BIT     11
`define PLCS_FLS_EN_BIT      10
`define PLCS_LCO_VAL_BIT     9
`define PLCS_LCO_EN_BIT      8

// ==========================================================
// timing
`define PLCS_CLK_MHZ         20
`define PLCS_US_SCALE        16
`define PLCS_US_CYCLES       (`PLCS_CLK_MHZ)

`endif

/* File: hw/plcs_pkg.sv */
// Purpose: types of the link config bank
// Assumes: nothing
// Notes:   constants live in plcs_defines.svh
package plcs_pkg;
    typedef enum logic [2:0] {
        PLCS_AP_IDLE = 3'b001,
        PLCS_AP_WR   = 3'b010,
        PLCS_AP_RD   = 3'b100
    } plcs_phase_e;

    typedef logic [15:0] plcs_word_t;
endpackage : plcs_pkg

/* File: verif/plcs_regs_monitor.sv */
// Purpose: port-level checks of the link config bank
// Assumes: one clock, async active-low reset
// Notes:   bound to every plcs_regs instance
`timescale 1ns/1ns
module plcs_regs_monitor (
    input wire logic        ref_clk_in,
    input wire logic        nrst_in,
    input wire logic        hsel_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        rx_symbol_valid_in,
    input wire logic        link_control_in,
    input wire logic        autoneg_en_in,
    input wire logic        maxwait_start_in,
    input wire logic        minwait_start_in,
    input wire logic [2:0]  sent_wake_symbol_out,
    input wire logic [2:0]  sent_sleep_symbol_out,
    input wire logic        wake_received_out,
    input wire logic        sleep_received_out,
    input wire logic        maxwait_done_out,
    input wire logic        minwait_done_out,
    input wire logic        fallback_lock_en_out,
    input wire logic        fallback_energy_en_out,
    input wire logic        bypass_dsp_reset_out,
    input wire logic        link_control_out
);
    default clocking dc @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    // ==========================================================
    // bus and register behaviour
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("slave not ready or not okay");
    a_rd_upper_zero: assert property (hrdata_out[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_rd_stands: assert property ($changed(hrdata_out) |->
        $past(hsel_in && hready_in && htrans_in[1] && !hwrite_in))
        else $error("read data changed without a read");
    a_cfg_by_write: assert property ($changed({sent_wake_symbol_out, sent_sleep_symbol_out,
        fallback_lock_en_out, fallback_energy_en_out, bypass_dsp_reset_out}) |->
        $past(hsel_in && htrans_in[1] && hwrite_in, 2))
        else $error("config output changed without a write");

    // ==========================================================
    // symbols, timers, link control
    a_wake_rise: assert property ($rose(wake_received_out) |-> $past(rx_symbol_valid_in))
        else $error("wake flag rose without a symbol");
    a_sleep_rise: assert property ($rose(sleep_received_out) |-> $past(rx_symbol_valid_in))
        else $error("sleep flag rose without a symbol");
    a_min_restart: assert property (minwait_start_in |=> !minwait_done_out)
        else $error("min timer done after start");
    a_max_restart: assert property (maxwait_start_in |=> !maxwait_done_out)
        else $error("max timer done after start");
    a_ctl_passthru: assert property (!autoneg_en_in |=>
        link_control_out == $past(link_control_in))
        else $error("link control overridden without autoneg");
endmodule : plcs_regs_monitor

bind plcs_regs plcs_regs_monitor u_mon (.*);

/* File: verif/tb.sv */
// Purpose: self-checking bench of the link config bank
// Assumes: zero-wait slave, index times four is the byte address
// Notes:   model kept in four words plus the status inputs
`timescale 1ns/1ns
`include "plcs_defines.svh"
module tb;
    localparam logic [3:0] REV = 4'ha; // arbitrary revision
    logic        ref_clk_in, nrst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, q;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in, rx_symbol_in, sent_wake_symbol_out, sent_sleep_symbol_out;
    logic [7:0]  echo_first_height_in, echo_second_height_in;
    logic [7:0]  echo_third_height_in, echo_fourth_height_in;
    logic [4:0]  echo_polarity_in;
    logic [15:0] reflect_summary_in, strap_low_in, strap_high_in, m_cod, m_thr, m_max, m_ctl;
    logic        rx_symbol_valid_in, real_link_status_in, link_control_in, autoneg_en_in;
    logic        maxwait_start_in, minwait_start_in, wake_received_out, sleep_received_out;
    logic        maxwait_done_out, minwait_done_out, fallback_lock_en_out, link_status_out;
    logic        fallback_energy_en_out, bypass_dsp_reset_out, link_control_out;
    int          bad_count, n_compared;
    localparam logic [11:0] IDX [13] = '{`PLCS_IDX_PEAK_A, `PLCS_IDX_PEAK_B, `PLCS_IDX_SIGNS,
        `PLCS_IDX_SUMMARY, `PLCS_IDX_STRAP_LO, `PLCS_IDX_STRAP_HI, `PLCS_IDX_REVISION,
        `PLCS_IDX_CODES, `PLCS_IDX_THRESH, `PLCS_IDX_MAXWAIT, `PLCS_IDX_PHYCTRL,
        12'h0000, 12'h0600};

    assign hready_in = hreadyout_out;
    plcs_regs #(.REV_VALUE(REV)) uut (.*);

    // ==========================================================
    // model and checks
    function automatic logic [15:0] expv(input logic [11:0] i);
        case (i)
            `PLCS_IDX_PEAK_A:   return {echo_second_height_in, echo_first_height_in};
            `PLCS_IDX_PEAK_B:   return {echo_fourth_height_in, echo_third_height_in};
            `PLCS_IDX_SIGNS:    return {11'h000, echo_polarity_in};
            `PLCS_IDX_SUMMARY:  return reflect_summary_in & 16'h3ff3;
            `PLCS_IDX_STRAP_LO: return strap_low_in;
            `PLCS_IDX_STRAP_HI: return strap_high_in;
            `PLCS_IDX_REVISION: return {12'h000, REV};
            `PLCS_IDX_CODES:    return m_cod;
            `PLCS_IDX_THRESH:   return m_thr;
            `PLCS_IDX_MAXWAIT:  return m_max;
            `PLCS_IDX_PHYCTRL:  return m_ctl;
            default:            return 16'h0000;
        endcase
    endfunction : expv

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // ==========================================================
    // bus master
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            end_sim();
        end
    endtask : wait_rdy

    task automatic xfer(input logic [11:0] i, input logic w, input logic [15:0] d);
        hsel_in   <= 1'b1;
        haddr_in  <= {18'h0_0000, i, 2'b00};
        htrans_in <= 2'b10;
        hwrite_in <= w;
        wait_rdy();
        htrans_in <= 2'b00;
        hwdata_in <= {16'h0000, d};
        wait_rdy();
        q = hrdata_out;
        if (w) case (i)
            `PLCS_IDX_CODES:   m_cod = d & 16'h0fff;
            `PLCS_IDX_THRESH:  m_thr = d & 16'h7f7f;
            `PLCS_IDX_MAXWAIT: m_max = d;
            `PLCS_IDX_PHYCTRL: m_ctl = d & 16'h7fff;
            default: ;
        endcase
    endtask : xfer

    task automatic rdchk(input logic [11:0] i);
        xfer(i, 1'b0, 16'h0000);
        chk("register", q, {16'h0000, expv(i)});
    endtask : rdchk

    task automatic send(input logic [2:0] c, input int n);
        rx_symbol_valid_in <= 1'b1;
        rx_symbol_in       <= c;
        repeat (n) @(posedge ref_clk_in);
    endtask : send

    task automatic idle3();
        rx_symbol_valid_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
    endtask : idle3

    task automatic tmr(input logic mx);
        int n;
        maxwait_start_in <= mx;
        minwait_start_in <= !mx;
        @(posedge ref_clk_in);
        maxwait_start_in <= 1'b0;
        minwait_start_in <= 1'b0;
        for (n = 0; (mx ? maxwait_done_out : minwait_done_out) !== 1'b1 && n < 400; n++)
            @(posedge ref_clk_in);
        chk("timer span", n >= 295 && n <= 345, 1);
    endtask : tmr

    task automatic rnd_status();
        {echo_first_height_in, echo_second_height_in} <= 16'($urandom);
        {echo_third_height_in, echo_fourth_height_in} <= 16'($urandom);
        {echo_polarity_in, reflect_summary_in} <= 21'($urandom);
        {strap_low_in, strap_high_in} <= $urandom;
    endtask : rnd_status

    // ==========================================================
    // stimulus
    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        {nrst_in, hsel_in, haddr_in, htrans_in, hwrite_in, hwdata_in, rx_symbol_in} = '0;
        {rx_symbol_valid_in, real_link_status_in, link_control_in, autoneg_en_in} = '0;
        {maxwait_start_in, minwait_start_in, bad_count, n_compared} = '0;
        hsize_in = 3'b010;
        {m_cod, m_thr, m_max, m_ctl} = {16'h08e3, 16'h0808, 16'h17ce, 16'h003d};
        void'($urandom(32'hae13_8698));
        rnd_status();
        repeat (5) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        for (int r = 0; r < 5; r++) begin
            if (r > 0) foreach (IDX[k]) xfer(IDX[k], 1'b1, 16'($urandom));
            foreach (IDX[k]) rdchk(IDX[k]);
            chk("codes out", {sent_wake_symbol_out, sent_sleep_symbol_out}, m_cod[11:6]);
            chk("ctl out", {fallback_lock_en_out, fallback_energy_en_out, bypass_dsp_reset_out},
                m_ctl[14:12]);
            rnd_status();
        end
        // mid-run reset: writable fields return to their reset values
        nrst_in <= 1'b0;
        @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        {m_cod, m_thr, m_max, m_ctl} = {16'h08e3, 16'h0808, 16'h17ce, 16'h003d};
        foreach (IDX[k]) rdchk(IDX[k]);
        chk("codes rst", {sent_wake_symbol_out, sent_sleep_symbol_out}, 6'h23);
        for (int v = 0; v < 64; v++) begin
            real_link_status_in <= v[4];
            autoneg_en_in       <= v[5];
            link_control_in     <= !v[4];
            xfer(`PLCS_IDX_PHYCTRL, 1'b1, {4'h0, v[3:0], 8'h01});
            repeat (2) @(posedge ref_clk_in);
            chk("link status", link_status_out, v[2] ? v[3] : v[4]);
            chk("link ctl", link_control_out, (v[5] && v[0]) ? v[1] : !v[4]);
        end
        xfer(`PLCS_IDX_CODES, 1'b1, {4'h0, 3'b100, 3'b011, 3'b101, 3'b010});
        xfer(`PLCS_IDX_THRESH, 1'b1, 16'h0302);
        send(3'b101, 2);
        send(3'b001, 1);
        send(3'b101, 2);
        idle3();
        chk("wake early", wake_received_out, 1'b0);
        send(3'b101, 3);
        idle3();
        chk("wake", wake_received_out, 1'b1);
        send(3'b010, 2);
        idle3();
        chk("sleep", {sleep_received_out, wake_received_out}, 2'b10);
        xfer(`PLCS_IDX_MAXWAIT, 1'b1, 16'h0001);
        tmr(1'b0);
        tmr(1'b1);
        end_sim();
    end
endmodule : tb
